// ==== core/qct_top.sv ====
// Four-channel 8-bit counter/timer with processor bus and interrupt daisy chain
//
// Functional notes
// R1 - Timer prescaler divides by 16 or 256.
// R2 - Count loads at start and reloads at every zero.
// R3 - Each zero pulses the zero-count pin high.
// R4 - 8-bit reload value, counts 1 to 256.
// R5 - Reload value follows its control word.
// R6 - Reload written while running applies at next zero.
// R7 - Counter mode counts pin edges, timer mode ticks.
// R8 - A read returns the selected count.
// R9 - Zero-count pins on channels 0 to 2 only.
// R10 - Channel 0 has highest priority.
// R11 - Lower priority never interrupts higher service.
// R12 - Acknowledge with chain input high drives vector.
// R13 - Vector is five base bits, channel, zero.
// R14 - Return opcode snoop ends service.
// R15 - Select pins form channel number, upper MSB.
// R16 - Write: request, enable, read strobe off.
// R17 - Read: request, enable, read strobe on.
// R18 - Cycle one with request is acknowledge.
// R19 - Chain out needs chain in and no service.
// R20 - Open-drain request on enabled zero.
// R21 - Reset stops channels and idles outputs.
// R22 - Trigger start waits for chosen pin edge.
// R23 - Byte with bit 0 set is a control word.
// R24 - Bit 6 counter, bit 5 prescale 256, bit 4 rising.
// R25 - Bit 7 enables interrupts, not retroactively.
// R26 - Auto start, or two clocks after trigger.
// R27 - Reload value zero means 256.
// R28 - Zero pulse lasts one clock.
`default_nettype none
module qct_top
    import qct_pkg::*;
(
    // Clock and reset
    input  wire logic                    mclk,
    input  wire logic                    rst,
    // Processor bus
    input  wire logic                    chip_enable_n,
    input  wire logic                    io_request_n,
    input  wire logic                    read_strobe_n,
    input  wire logic                    first_machine_cycle_n,
    input  wire logic                    channel_select_msb,
    input  wire logic                    channel_select_lsb,
    input  wire logic [QCT_DATA_W-1:0]   data_in,
    output logic      [QCT_DATA_W-1:0]   data_out,
    output logic                         data_oe,
    // Interrupt and daisy chain
    output logic                         int_req_n_out,
    output logic                         int_req_n_oe,
    input  wire logic                    chain_enable_in,
    output logic                         chain_enable_out,
    // Channel pins
    input  wire logic [QCT_CHANNELS-1:0] ext_clock_or_trigger_in,
    output logic      [QCT_ZC_PINS-1:0]  zero_count_pulse_out
);
    // Per-channel registers and the shared vector base
    logic [QCT_DATA_W-1:0]   ctrl_ff  [QCT_CHANNELS];
    logic [QCT_DATA_W-1:0]   tc_ff    [QCT_CHANNELS];
    logic [QCT_DATA_W-1:0]   cnt_ff   [QCT_CHANNELS];
    logic [QCT_CHANNELS-1:0] tc_exp_ff;
    logic [QCT_CHANNELS-1:0] run_ff;
    logic [QCT_CHANNELS-1:0] arm_ff;
    logic [QCT_CHANNELS-1:0] start_ff;
    logic [QCT_CHANNELS-1:0] ext_prev_ff;
    logic [QCT_VBASE_W-1:0]  vbase_ff;

    // Bus tracking
    logic                    wr_prev_ff;
    logic                    ack_prev_ff;
    logic                    fetch_prev_ff;
    logic [QCT_DATA_W-1:0]   fetch_data_ff;
    logic                    prefix_ff;
    logic                    return_from_irq_opcode_ff;

    // Output registers
    logic [QCT_DATA_W-1:0]   data_out_ff;
    logic                    data_oe_ff;
    logic                    int_oe_ff;
    logic                    chain_out_ff;
    logic [QCT_ZC_PINS-1:0]  zc_ff;

    // Decoded strobes
    logic [QCT_SEL_W-1:0]    sel;
    logic                    wr_cond;
    logic                    rd_cond;
    logic                    ack_cond;
    logic                    fetch_cond;
    logic                    wr_pulse;
    logic                    ack_pulse;
    logic [QCT_CHANNELS-1:0] ctrl_load;
    logic [QCT_CHANNELS-1:0] tc_load;
    logic                    vec_load;
    logic [QCT_CHANNELS-1:0] trig_edge;
    logic [QCT_CHANNELS-1:0] ps_tick;
    logic [QCT_CHANNELS-1:0] dec;
    logic [QCT_CHANNELS-1:0] zero_evt;
    logic [QCT_CHANNELS-1:0] ie_bits;

    qct_irq_if irq ();

    // Bus cycle decode
    assign sel        = {channel_select_msb, channel_select_lsb};   // R15
    assign ack_cond   = !first_machine_cycle_n && !io_request_n;   // R18
    assign wr_cond    = !io_request_n && !chip_enable_n && read_strobe_n
                        && first_machine_cycle_n;   // R16
    assign rd_cond    = !io_request_n && !chip_enable_n && !read_strobe_n
                        && first_machine_cycle_n;   // R17
    assign fetch_cond = !first_machine_cycle_n && !read_strobe_n && io_request_n;
    assign wr_pulse   = wr_cond && !wr_prev_ff;
    assign ack_pulse  = ack_cond && !ack_prev_ff;

    // Edge history of the bus strobes
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            wr_prev_ff    <= 1'b0;
            ack_prev_ff   <= 1'b0;
            fetch_prev_ff <= 1'b0;
        end
        else
        begin
            wr_prev_ff    <= wr_cond;
            ack_prev_ff   <= ack_cond;
            fetch_prev_ff <= fetch_cond;
        end
    end

    // Sort written bytes
    always_comb
    begin
        ctrl_load = '0;
        tc_load   = '0;
        vec_load  = 1'b0;
        if (wr_pulse)
        begin
            if (tc_exp_ff[sel])
                tc_load[sel] = 1'b1;   // R5
            else if (data_in[QCT_CW_CTRL])
                ctrl_load[sel] = 1'b1;   // R23
            else if (sel == QCT_VEC_CH)
                vec_load = 1'b1;
        end
    end

    // Stored words
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            for (int c = 0; c < QCT_CHANNELS; c++)
            begin
                ctrl_ff[c] <= QCT_CTRL_RESET;   // R21
                tc_ff[c]   <= QCT_TC_RESET;
            end
            tc_exp_ff <= '0;
            vbase_ff  <= QCT_VBASE_RESET;
        end
        else
        begin
            for (int c = 0; c < QCT_CHANNELS; c++)
            begin
                if (ctrl_load[c])
                begin
                    ctrl_ff[c]   <= data_in;   // R24
                    tc_exp_ff[c] <= data_in[QCT_CW_TCF];
                end
                else if (tc_load[c])
                begin
                    tc_ff[c]     <= data_in;   // R4
                    tc_exp_ff[c] <= 1'b0;
                end
            end
            if (vec_load)
                vbase_ff <= data_in[QCT_DATA_W-1:QCT_VB_LSB];   // R13
        end
    end

    // Trigger pin history
    always_ff @(posedge mclk)
    begin
        if (rst)
            ext_prev_ff <= '0;
        else
            ext_prev_ff <= ext_clock_or_trigger_in;
    end

    // Per-channel decrement
    for (genvar c = 0; c < QCT_CHANNELS; c++)
    begin : g_ch
        assign trig_edge[c] = ctrl_ff[c][QCT_CW_EDGE]
                            ? (ext_clock_or_trigger_in[c] && !ext_prev_ff[c])
                            : (!ext_clock_or_trigger_in[c] && ext_prev_ff[c]);

        qct_prescaler #(
            .W      (QCT_PS_W)
        ) u_presc (
            .mclk   (mclk),
            .rst    (rst),
            .run    (run_ff[c] && !ctrl_ff[c][QCT_CW_MODE]),
            .div256 (ctrl_ff[c][QCT_CW_PRESC]),
            .tick   (ps_tick[c])
        );   // R1

        assign dec[c] = run_ff[c] && (ctrl_ff[c][QCT_CW_MODE]
                        ? trig_edge[c] : ps_tick[c]);   // R7
        assign zero_evt[c] = dec[c] && (cnt_ff[c] == QCT_CNT_LAST);
        assign ie_bits[c]  = ctrl_ff[c][QCT_CW_IE];
    end

    // Start and stop of each channel
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            run_ff   <= '0;   // R21
            arm_ff   <= '0;
            start_ff <= '0;
        end
        else
        begin
            for (int c = 0; c < QCT_CHANNELS; c++)
            begin
                if (ctrl_load[c] && data_in[QCT_CW_SRST])
                begin
                    run_ff[c]   <= 1'b0;
                    arm_ff[c]   <= 1'b0;
                    start_ff[c] <= 1'b0;
                end
                else if (tc_load[c] && !run_ff[c])
                begin
                    if (ctrl_ff[c][QCT_CW_TRIG] && !ctrl_ff[c][QCT_CW_MODE])
                        arm_ff[c] <= 1'b1;   // R22
                    else
                        run_ff[c] <= 1'b1;   // R26
                end
                else if (arm_ff[c] && trig_edge[c])
                begin
                    arm_ff[c]   <= 1'b0;   // R22
                    start_ff[c] <= 1'b1;
                end
                else if (start_ff[c])
                begin
                    start_ff[c] <= 1'b0;
                    run_ff[c]   <= 1'b1;   // R26
                end
            end
        end
    end

    // Down-counters
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            for (int c = 0; c < QCT_CHANNELS; c++)
                cnt_ff[c] <= QCT_CNT_RESET;
        end
        else
        begin
            for (int c = 0; c < QCT_CHANNELS; c++)
            begin
                if (tc_load[c] && !run_ff[c])
                    cnt_ff[c] <= data_in;   // R2
                else if (zero_evt[c])
                    cnt_ff[c] <= tc_ff[c];   // R6
                else if (dec[c])
                    cnt_ff[c] <= cnt_ff[c] - QCT_CNT_LAST;   // R27
            end
        end
    end

    // Zero-count pins
    always_ff @(posedge mclk)
    begin
        if (rst)
            zc_ff <= '0;   // R21
        else
            zc_ff <= zero_evt[QCT_ZC_PINS-1:0];   // R3 R9 R28
    end

    // Return opcode snoop
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            fetch_data_ff <= '0;
            prefix_ff     <= 1'b0;
            return_from_irq_opcode_ff       <= 1'b0;
        end
        else
        begin
            return_from_irq_opcode_ff <= 1'b0;
            if (fetch_cond)
                fetch_data_ff <= data_in;
            else if (fetch_prev_ff)
            begin
                prefix_ff <= (fetch_data_ff == QCT_OPC_PREFIX);
                return_from_irq_opcode_ff   <= prefix_ff && (fetch_data_ff == QCT_OPC_RETURN_FROM_IRQ_OPCODE);   // R14
            end
        end
    end

    // Interrupt priority logic
    assign irq.zero_evt = zero_evt;
    assign irq.ie       = ie_bits;
    assign irq.ack      = ack_pulse;
    assign irq.return_from_irq_opcode     = return_from_irq_opcode_ff;
    assign irq.chain_in = chain_enable_in;

    qct_irq_ctl u_irq (
        .mclk (mclk),
        .rst  (rst),
        .irq  (irq.ctl)
    );

    // Data bus drive
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            data_out_ff <= '0;
            data_oe_ff  <= 1'b0;   // R21
        end
        else if (rd_cond)
        begin
            data_out_ff <= cnt_ff[sel];   // R8
            data_oe_ff  <= 1'b1;
        end
        else if (ack_pulse)
        begin
            data_out_ff <= {vbase_ff, irq.vec_ch, 1'b0};   // R13
            data_oe_ff  <= chain_enable_in && irq.vec_valid;   // R12
        end
        else if (!ack_cond)
            data_oe_ff <= 1'b0;
    end

    // Request and chain out
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            int_oe_ff    <= 1'b0;   // R21
            chain_out_ff <= chain_enable_in;   // R21
        end
        else
        begin
            int_oe_ff    <= irq.req;   // R20
            chain_out_ff <= chain_enable_in && !irq.busy;   // R19
        end
    end

    // Port drive
    assign data_out             = data_out_ff;
    assign data_oe              = data_oe_ff;
    assign int_req_n_out        = 1'b0;   // Open drain
    assign int_req_n_oe         = int_oe_ff;
    assign chain_enable_out     = chain_out_ff;
    assign zero_count_pulse_out = zc_ff;
endmodule : qct_top
`default_nettype wire

// ==== core/qct_pkg.sv ====
// Shared constants, control-word layout and a helper function for the quad counter/timer
`default_nettype none
package qct_pkg;
    // Sizes
    localparam int QCT_CHANNELS = 4;
    localparam int QCT_ZC_PINS  = 3;
    localparam int QCT_DATA_W   = 8;
    localparam int QCT_SEL_W    = 2;
    localparam int QCT_VBASE_W  = 5;
    localparam int QCT_PS_W     = 8;

    // Control word bit positions
    localparam int QCT_CW_IE    = 7;   // Zero-count interrupt enable
    localparam int QCT_CW_MODE  = 6;   // 1 counter, 0 timer
    localparam int QCT_CW_PRESC = 5;   // 1 divide by 256, 0 by 16
    localparam int QCT_CW_EDGE  = 4;   // 1 rising, 0 falling
    localparam int QCT_CW_TRIG  = 3;   // 1 timer waits for trigger edge
    localparam int QCT_CW_TCF   = 2;   // 1 reload value follows
    localparam int QCT_CW_SRST  = 1;   // 1 stop the channel
    localparam int QCT_CW_CTRL  = 0;   // 1 marks a control word
    localparam int QCT_VB_LSB   = 3;   // Vector base field low bit in written byte

    // Reset values and fixed codes
    localparam logic [QCT_DATA_W-1:0]  QCT_CTRL_RESET  = 8'h00;
    localparam logic [QCT_DATA_W-1:0]  QCT_TC_RESET    = 8'h00;
    localparam logic [QCT_DATA_W-1:0]  QCT_CNT_RESET   = 8'h00;
    localparam logic [QCT_DATA_W-1:0]  QCT_CNT_LAST    = 8'h01;
    localparam logic [QCT_VBASE_W-1:0] QCT_VBASE_RESET = 5'h00;
    localparam logic [QCT_SEL_W-1:0]   QCT_VEC_CH      = 2'h0;
    localparam logic [QCT_DATA_W-1:0]  QCT_OPC_PREFIX  = 8'hed;
    localparam logic [QCT_DATA_W-1:0]  QCT_OPC_RETURN_FROM_IRQ_OPCODE    = 8'h4d;
    localparam logic [QCT_PS_W-1:0]    QCT_PS16_MASK   = 8'h0f;
    localparam logic [QCT_PS_W-1:0]    QCT_PS256_MASK  = 8'hff;

    // Lowest set bit index
    function automatic logic [QCT_SEL_W-1:0] qct_first_set(input logic [QCT_CHANNELS-1:0] v);
        logic [QCT_SEL_W-1:0] idx;
        idx = '0;
        for (int i = QCT_CHANNELS - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                idx = QCT_SEL_W'(i);
            end
        end
        return idx;
    endfunction : qct_first_set
endpackage : qct_pkg
`default_nettype wire

// ==== core/qct_irq_if.sv ====
// Signals between the channel core and the interrupt priority logic
`default_nettype none
interface qct_irq_if;
    logic [3:0] zero_evt;   // Zero-count events of all channels, not masked by ie
    logic [3:0] ie;         // Interrupt enables
    logic       ack;        // Acknowledge start pulse
    logic       return_from_irq_opcode;       // Return-from-interrupt seen
    logic       chain_in;   // Daisy-chain enable from upstream
    logic       req;        // Interrupt request level
    logic       vec_valid;  // A channel may be vectored
    logic [1:0] vec_ch;     // Channel to vector
    logic       busy;       // Some channel in service

    modport core (output zero_evt, ie, ack, return_from_irq_opcode, chain_in,
                  input  req, vec_valid, vec_ch, busy);
    modport ctl  (input  zero_evt, ie, ack, return_from_irq_opcode, chain_in,
                  output req, vec_valid, vec_ch, busy);
endinterface : qct_irq_if
`default_nettype wire

// ==== core/qct_prescaler.sv ====
// Timer prescaler, held clear while idle, giving one tick every 16 or 256 clocks
`default_nettype none
module qct_prescaler
    import qct_pkg::*;
#(
    parameter int W = QCT_PS_W
)
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // Control
    input  wire logic run,
    input  wire logic div256,
    // Tick out
    output logic      tick
);
    logic [W-1:0] ps_ff;
    logic [W-1:0] mask;

    // Divider counter restarts whenever the timer is idle
    always_ff @(posedge mclk)
    begin
        if (rst || !run)
            ps_ff <= '0;
        else
            ps_ff <= ps_ff + W'(1);
    end

    // Tick on the last state of the selected ratio
    assign mask = div256 ? W'(QCT_PS256_MASK) : W'(QCT_PS16_MASK);
    assign tick = run && ((ps_ff & mask) == mask);
endmodule : qct_prescaler
`default_nettype wire

// ==== core/qct_irq_ctl.sv ====
// Pending and in-service tracking with fixed channel priority
`default_nettype none
module qct_irq_ctl
    import qct_pkg::*;
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // Core side
    qct_irq_if.ctl    irq
);
    logic [QCT_CHANNELS-1:0] pend_ff;
    logic [QCT_CHANNELS-1:0] isvc_ff;
    logic [QCT_CHANNELS-1:0] elig;

    // Eligible when nothing of equal or higher priority is in service
    always_comb
    begin
        logic blocked;
        blocked = 1'b0;
        for (int i = 0; i < QCT_CHANNELS; i++)
        begin
            blocked = blocked | isvc_ff[i];
            elig[i] = pend_ff[i] & !blocked;   // R11
        end
    end

    // Priority answer for the acknowledge
    assign irq.vec_valid = |elig;
    assign irq.vec_ch    = qct_first_set(elig);   // R10
    assign irq.req       = irq.chain_in & (|elig);   // R20
    assign irq.busy      = |isvc_ff;

    // Pending flags: zero event wins over clear
    always_ff @(posedge mclk)
    begin
        if (rst)
            pend_ff <= '0;   // R21
        else
        begin
            for (int i = 0; i < QCT_CHANNELS; i++)
            begin
                if (irq.zero_evt[i] && irq.ie[i])
                    pend_ff[i] <= 1'b1;   // R25
                else if (!irq.ie[i])
                    pend_ff[i] <= 1'b0;
                else if (irq.ack && irq.chain_in && irq.vec_valid
                         && irq.vec_ch == QCT_SEL_W'(i))
                    pend_ff[i] <= 1'b0;
            end
        end
    end

    // In-service flags
    always_ff @(posedge mclk)
    begin
        if (rst)
            isvc_ff <= '0;
        else
        begin
            for (int i = 0; i < QCT_CHANNELS; i++)
            begin
                if (irq.ack && irq.chain_in && irq.vec_valid
                    && irq.vec_ch == QCT_SEL_W'(i))
                    isvc_ff[i] <= 1'b1;   // R11
                else if (irq.return_from_irq_opcode && irq.chain_in && (|isvc_ff)
                         && qct_first_set(isvc_ff) == QCT_SEL_W'(i))
                    isvc_ff[i] <= 1'b0;   // R14
            end
        end
    end
endmodule : qct_irq_ctl
`default_nettype wire

// ==== testbench/qct_top_asserts.sv ====
// Port-level checker for the quad counter/timer top module
`default_nettype none
module qct_top_asserts
    import qct_pkg::*;
(
    // Clock and reset
    input wire logic                    mclk,
    input wire logic                    rst,
    // Processor bus
    input wire logic                    chip_enable_n,
    input wire logic                    io_request_n,
    input wire logic                    read_strobe_n,
    input wire logic                    first_machine_cycle_n,
    input wire logic [QCT_DATA_W-1:0]   data_out,
    input wire logic                    data_oe,
    // Interrupt and daisy chain
    input wire logic                    int_req_n_out,
    input wire logic                    int_req_n_oe,
    input wire logic                    chain_enable_in,
    input wire logic                    chain_enable_out,
    // Channel pins
    input wire logic [QCT_ZC_PINS-1:0]  zero_count_pulse_out
);
    // Bus cycle decodes
    logic rd_c;
    logic wr_c;
    logic ack_c;
    assign rd_c  = !io_request_n && !chip_enable_n && !read_strobe_n && first_machine_cycle_n;
    assign wr_c  = !io_request_n && !chip_enable_n && read_strobe_n && first_machine_cycle_n;
    assign ack_c = !io_request_n && !first_machine_cycle_n;

    // Single clock domain
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    AST_ZC_ONE: assert property ((zero_count_pulse_out & $past(zero_count_pulse_out)) == 3'h0)
        else $error("wide zero pulse");
    AST_RST_IDLE: assert property ($fell(rst) |-> !data_oe && !int_req_n_oe &&
        zero_count_pulse_out == 3'h0 && chain_enable_out == $past(chain_enable_in))
        else $error("not idle after reset");
    AST_CHAIN: assert property (chain_enable_out |-> $past(chain_enable_in))
        else $error("chain out without chain in");
    AST_INT_LOW: assert property (int_req_n_oe |-> int_req_n_out == 1'b0)
        else $error("request driven high");
    AST_READ: assert property (rd_c |=> data_oe)
        else $error("read not answered");
    AST_NO_DRIVE: assert property (data_oe |-> $past(ack_c || rd_c))
        else $error("stray bus drive");
    AST_WRITE: assert property (wr_c |=> !data_oe)
        else $error("bus driven in write");
    AST_ACK_BLOCK: assert property (ack_c && !chain_enable_in |=> !data_oe)
        else $error("vector without chain in");
    AST_ACK_VEC: assert property (ack_c && !$past(ack_c) && chain_enable_in && int_req_n_oe
        |=> data_oe)
        else $error("no vector on acknowledge");
    AST_VEC_LSB: assert property (data_oe && $past(ack_c) |-> data_out[0] == 1'b0)
        else $error("vector bit 0 set");
endmodule : qct_top_asserts

bind qct_top qct_top_asserts u_chk (
    .mclk (mclk),
    .rst (rst),
    .chip_enable_n (chip_enable_n),
    .io_request_n (io_request_n),
    .read_strobe_n (read_strobe_n),
    .first_machine_cycle_n (first_machine_cycle_n),
    .data_out (data_out),
    .data_oe (data_oe),
    .int_req_n_out (int_req_n_out),
    .int_req_n_oe (int_req_n_oe),
    .chain_enable_in (chain_enable_in),
    .chain_enable_out (chain_enable_out),
    .zero_count_pulse_out (zero_count_pulse_out)
);
`default_nettype wire

// ==== testbench/qct_cpu_model.sv ====
// Processor bus model: I/O writes, reads, acknowledges and opcode fetches
`default_nettype none
module qct_cpu_model
    import qct_pkg::*;
(
    // Clock
    input  wire logic                  mclk,
    // Bus strobes
    output logic                       chip_enable_n,
    output logic                       io_request_n,
    output logic                       read_strobe_n,
    output logic                       first_machine_cycle_n,
    output logic [1:0]                 sel,
    output logic [QCT_DATA_W-1:0]      cpu_data,
    // Device answer
    input  wire logic [QCT_DATA_W-1:0] data_out,
    input  wire logic                  data_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial
    begin
        {chip_enable_n, io_request_n, read_strobe_n, first_machine_cycle_n} = 4'hf;
        sel = 2'h0;
        cpu_data = 8'h5a;
    end

    // One-byte write; next call leaves an idle cycle first
    task automatic wr(input logic [1:0] ch, input logic [7:0] d);
        @(posedge mclk);
        #1;
        sel = ch;
        cpu_data = d;
        {io_request_n, chip_enable_n} = 2'b00;
        @(posedge mclk);
        #1;
        {io_request_n, chip_enable_n} = 2'b11;
        cpu_data = ~d;
    endtask : wr

    // Read, acknowledge or fetch; answer taken two edges after the strobes
    task automatic cyc(input logic [3:0] s, input logic [7:0] d, output logic [8:0] r);
        @(posedge mclk);
        #1;
        {chip_enable_n, io_request_n, read_strobe_n, first_machine_cycle_n} = s;
        cpu_data = d;
        @(posedge mclk);
        @(posedge mclk);
        #1;
        r = {data_oe, data_out};
        {chip_enable_n, io_request_n, read_strobe_n, first_machine_cycle_n} = 4'hf;
        cpu_data = ~d;
    endtask : cyc
endmodule : qct_cpu_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the quad counter/timer
`default_nettype none
module tb_top
    import qct_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic       mclk, rst, chain_in, ce_n, io_request_n_n, rd_n, m1_n, doe, ioe, iout, cout;
    logic [1:0] sel;
    logic [7:0] cpu_d, dout, din;
    logic [3:0] ext;
    logic [2:0] zc;
    logic [8:0] r;
    int         err_count, samples_checked, cyc_n, zcn[3], per[3], last[3];

    // Bus wire: device drives when enabled
    assign din = doe ? dout : cpu_d;

    qct_cpu_model cpu (.mclk(mclk), .chip_enable_n(ce_n), .io_request_n(io_request_n_n),
        .read_strobe_n(rd_n), .first_machine_cycle_n(m1_n), .sel(sel), .cpu_data(cpu_d),
        .data_out(dout), .data_oe(doe));

    qct_top uut (.mclk(mclk), .rst(rst), .chip_enable_n(ce_n), .io_request_n(io_request_n_n),
        .read_strobe_n(rd_n), .first_machine_cycle_n(m1_n), .channel_select_msb(sel[1]),
        .channel_select_lsb(sel[0]), .data_in(din), .data_out(dout), .data_oe(doe),
        .int_req_n_out(iout), .int_req_n_oe(ioe), .chain_enable_in(chain_in),
        .chain_enable_out(cout), .ext_clock_or_trigger_in(ext), .zero_count_pulse_out(zc));

    // Clock
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Zero-count pulse counts and periods
    always @(posedge mclk)
    begin
        cyc_n <= cyc_n + 1;
        for (int i = 0; i < 3; i++)
            if (zc[i] === 1'b1)
            begin
                zcn[i] <= zcn[i] + 1;
                per[i] <= cyc_n - last[i];
                last[i] <= cyc_n;
            end
    end

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp

    task automatic stop_test;
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test

    // Trigger pins high then low
    task automatic pulse(input logic [3:0] m);
        repeat (2) @(posedge mclk);
        #1 ext = ext | m;
        repeat (2) @(posedge mclk);
        #1 ext = ext & ~m;
    endtask : pulse

    task automatic wait_zc(input int ch, input int n, input int lim);
        for (int i = 0; i < lim && zcn[ch] < n; i++)
            @(posedge mclk);
        cmp(16'(zcn[ch]), 16'(n));
    endtask : wait_zc

    task automatic t_counter;
        cpu.wr(2'h1, 8'h55);
        cpu.wr(2'h1, 8'h03);
        for (int k = 3; k > 0; k--)
        begin
            cpu.cyc(4'h1, 8'h00, r);
            cmp(r, {1'b1, 8'(k)});
            pulse(4'h2);
        end
        cpu.cyc(4'h1, 8'h00, r);
        cmp(r, 9'h103);
        cmp(16'(zcn[1]), 16'h1);
        cpu.wr(2'h0, 8'h45);
        cpu.wr(2'h0, 8'h00);
        pulse(4'h1);
        cpu.cyc(4'h1, 8'h00, r);
        cmp(r, 9'h1ff);
    endtask : t_counter

    task automatic t_timer;
        cpu.wr(2'h2, 8'h05);
        cpu.wr(2'h2, 8'h02);
        wait_zc(2, 2, 100);
        cmp(16'(per[2]), 16'd32);
        cpu.wr(2'h2, 8'h05);
        cpu.wr(2'h2, 8'h01);
        wait_zc(2, zcn[2] + 1, 40);
        cmp(16'(per[2]), 16'd32);
        wait_zc(2, zcn[2] + 1, 40);
        cmp(16'(per[2]), 16'd16);
        cpu.wr(2'h2, 8'h25);
        cpu.wr(2'h2, 8'h01);
        wait_zc(2, zcn[2] + 2, 600);
        cmp(16'(per[2]), 16'd256);
        cpu.wr(2'h2, 8'h03);
    endtask : t_timer

    task automatic t_trigger;
        cpu.wr(2'h0, 8'h1f);
        cpu.wr(2'h0, 8'h01);
        repeat (40) @(posedge mclk);
        cmp(16'(zcn[0]), 16'h0);
        pulse(4'h1);
        wait_zc(0, 1, 40);
        cpu.wr(2'h0, 8'h03);
    endtask : t_trigger

    task automatic t_irq;
        cpu.wr(2'h0, 8'ha8);
        cpu.wr(2'h1, 8'hd7);
        cpu.wr(2'h1, 8'h01);
        cpu.wr(2'h0, 8'hd5);
        cpu.wr(2'h0, 8'h01);
        pulse(4'h3);
        repeat (4) @(posedge mclk);
        cmp(ioe, 1'b1);
        #1 chain_in = 1'b0;
        cpu.cyc(4'ha, 8'h00, r);
        cmp(r[8], 1'b0);
        #1 chain_in = 1'b1;
        repeat (3) @(posedge mclk);
        cpu.cyc(4'ha, 8'h00, r);
        cmp(r, 9'h1a8);
        repeat (2) @(posedge mclk);
        cmp({cout, ioe}, 2'b00);
        cpu.cyc(4'h4, QCT_OPC_PREFIX, r);
        cpu.cyc(4'h4, QCT_OPC_RETURN_FROM_IRQ_OPCODE, r);
        repeat (3) @(posedge mclk);
        #1 cmp({cout, ioe}, 2'b11);
        cpu.cyc(4'ha, 8'h00, r);
        cmp(r, 9'h1aa);
    endtask : t_irq

    // Watchdog
    initial
    begin
        repeat (20000) @(posedge mclk);
        err_count++;
        $display("MISMATCH %0t watchdog expired", $time);
        stop_test();
    end

    // Main sequence
    initial
    begin
        {rst, chain_in, ext, cyc_n} = {2'b11, 4'h0, 32'd0};
        zcn = '{0, 0, 0};
        last = '{0, 0, 0};
        repeat (10) @(posedge mclk);
        #1 rst = 1'b0;
        @(posedge mclk);
        #1;
        cmp({doe, ioe, zc, cout}, 6'h01);
        t_counter();
        t_timer();
        t_trigger();
        t_irq();
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
